// ---- mdbi_defs.svh ----
// Purpose: Shared constants for the multichannel DMA bus interface.
// Assumes: Included by bare name from the package and the design modules.
// Notes:   Every offset, width and count used in the logic lives here; the state encoding is in the package.
`ifndef MDBI_DEFS_SVH
`define MDBI_DEFS_SVH

// ****************************************************************
// Channel layout
// ****************************************************************
`define MDBI_NCH 10
`define MDBI_CW 4
`define MDBI_GEN_CH 8
`define MDBI_LAST_CH 4'h9

// ****************************************************************
// Widths and depths
// ****************************************************************
`define MDBI_SW 16
`define MDBI_BW 32
`define MDBI_AW 32
`define MDBI_LW 16
`define MDBI_BEW 4
`define MDBI_WW 36
`define MDBI_DEPTH 4
`define MDBI_KW 3
`define MDBI_BURST 3'h4
`define MDBI_ROOM 3'h3

// ****************************************************************
// Byte enables, address steps and small constants
// ****************************************************************
`define MDBI_BE_FULL 4'hF
`define MDBI_BE_HI 4'hC
`define MDBI_BE_LO 4'h3
`define MDBI_ADDR_STEP 32'h0000_0004
`define MDBI_WORD_MASK 32'hFFFF_FFFC
`define MDBI_HALF_BIT 1
`define MDBI_ONE16 16'h0001
`define MDBI_ONE3 3'h1
`define MDBI_ONE4 4'h1
`define MDBI_ZERO16 16'h0000

`endif

// ---- mdbi_fifo.sv ----
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Push and pop may happen in the same cycle; count is exact.
`timescale 1ns/1ps
`include "mdbi_defs.svh"

module mdbi_fifo #(
    parameter int W = `MDBI_WW,
    parameter int D = `MDBI_DEPTH
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Fill side.
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    // Drain side.
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data,
    // Fill level.
    output logic [$clog2(D+1)-1:0] o_count
);
    import mdbi_pkg::*;

    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D+1);

    // All state of the FIFO: storage, pointers and fill count.
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } mdbi_fifo_s;

    mdbi_fifo_s st_q; // Registered state.
    mdbi_fifo_s st_d; // Next state.
    logic push; // Word enters this cycle.
    logic pop; // Word leaves this cycle.

    // Full and empty come straight from the count, so they are never stale.
    assign o_in_ready = (st_q.cnt != CW'(D));
    assign o_out_valid = (st_q.cnt != '0);
    assign o_out_data = st_q.mem[st_q.rp];
    assign o_count = st_q.cnt;
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_ready && o_out_valid;

    // Next-state logic; pointers wrap at the depth, which need not be a power of two.
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = i_in_data;
            st_d.wp = (st_q.wp == AW'(D-1)) ? '0 : st_q.wp + AW'(1);
        end
        if (pop) begin
            st_d.rp = (st_q.rp == AW'(D-1)) ? '0 : st_q.rp + AW'(1);
        end
        st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
    end

    // State register.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule

// ---- mdbi_host_model.sv ----
// Purpose: Host memory model behind the write, read and completion ports.
// Assumes: Word at address w holds w[15:0] low and w[15:0]+2 high.
// Notes:   Ready lines stall now and then; i_stall blocks writes.
`timescale 1ns/1ps
`include "mdbi_defs.svh"

module mdbi_host_model (
    // Clock, reset and test control.
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_stall,
    // Read requests and completions.
    input wire mdbi_pkg::mdbi_hrd_s i_host_rd,
    input wire logic i_cpl_ready,
    output logic o_rd_ready,
    output logic o_wr_ready,
    output mdbi_pkg::mdbi_cpl_s o_cpl
);
    import mdbi_pkg::*;
    logic [7:0] cnt_q; // Free counter that shapes the stalls.
    logic [31:0] aq[$]; // Word addresses still owed to the device.
    logic [31:0] w;
    // Memory answers in request order, never ahead of a request.
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 8'h00;
            o_wr_ready <= 1'b0;
            o_rd_ready <= 1'b0;
            o_cpl <= '0;
            aq.delete();
        end else begin
            cnt_q <= cnt_q + 8'h01;
            o_wr_ready <= !i_stall && cnt_q[1:0] != 2'h3;
            o_rd_ready <= cnt_q[0];
            if (!o_cpl.valid || i_cpl_ready) begin
                if (aq.size() > 0 && cnt_q[2:0] != 3'h5) begin
                    w = aq.pop_front();
                    o_cpl <= '{1'b1, {w[15:0] + 16'h0002, w[15:0]}};
                end else begin
                    // A released bus shows junk, not the last word.
                    o_cpl <= '{1'b0, ~o_cpl.data};
                end
            end
            if (i_host_rd.valid && o_rd_ready) begin
                for (int i = 0; i < i_host_rd.beats; i++) begin
                    aq.push_back((i_host_rd.addr & 32'hFFFF_FFFC) + 32'(4 * i));
                end
            end
        end
    end
endmodule

// ---- mdbi_pkg.sv ----
// Purpose: Types shared by the DMA bus interface modules.
// Assumes: mdbi_defs.svh gives all sizes.
// Notes:   Constants stay in the header; this package holds the types only.
`include "mdbi_defs.svh"

package mdbi_pkg;

    // ****************************************************************
    // Carrier types
    // ****************************************************************

    // One transfer set-up for one channel: byte start address and sample count.
    typedef struct packed {
        logic valid;
        logic [`MDBI_AW-1:0] addr;
        logic [`MDBI_LW-1:0] nsamp;
    } mdbi_desc_s;

    // One bus word with its byte enables, as kept in a channel FIFO.
    typedef struct packed {
        logic [`MDBI_BEW-1:0] be;
        logic [`MDBI_BW-1:0] data;
    } mdbi_word_s;

    // One write beat towards host memory.
    typedef struct packed {
        logic valid;
        logic [`MDBI_CW-1:0] chan;
        logic [`MDBI_AW-1:0] addr;
        mdbi_word_s word;
        logic last;
    } mdbi_hwr_s;

    // One read burst request towards host memory.
    typedef struct packed {
        logic valid;
        logic [`MDBI_AW-1:0] addr;
        logic [`MDBI_KW-1:0] beats;
    } mdbi_hrd_s;

    // One read completion word from host memory.
    typedef struct packed {
        logic valid;
        logic [`MDBI_BW-1:0] data;
    } mdbi_cpl_s;

    // One block-side sample.
    typedef struct packed {
        logic valid;
        logic [`MDBI_SW-1:0] data;
    } mdbi_smp_s;

    // Write engine states.
    typedef enum logic [0:0] {
        MDBI_WR_IDLE,
        MDBI_WR_BURST
    } mdbi_wr_e;

endpackage

// ---- mdbi_top.sv ----
// Purpose: Ten-channel DMA bus interface between host memory and the measurement blocks.
// Assumes: One clock, i_core_clk at 100 MHz; asynchronous active-high reset i_rst.
// Notes:   Channels 0-7 and 9 move block samples to host; channel 8 moves host data out.
//
// Functional notes
// - Ten DMA channels run fully independently.
// - Counters 0-7, generation 8, acquisition 9.
// - Each channel has its own FIFO.
// - Host and block sides move data concurrently.
// - Burst transfers into and out of FIFOs.
// - Pack samples to host, unpack from host.
// - Unaligned buffer start and length handled.
// - No processor needed once transfer set up.
// - DMA is the default transfer method.
`timescale 1ns/1ps
`include "mdbi_defs.svh"

module mdbi_top (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Transfer set-up, one per channel.
    input wire mdbi_pkg::mdbi_desc_s [`MDBI_NCH-1:0] i_desc,
    output logic [`MDBI_NCH-1:0] o_busy,
    output logic [`MDBI_NCH-1:0] o_done,
    // Block-side acquisition samples.
    input wire mdbi_pkg::mdbi_smp_s [`MDBI_NCH-1:0] i_blk_in,
    output logic [`MDBI_NCH-1:0] o_blk_in_ready,
    // Block-side generation samples.
    output mdbi_pkg::mdbi_smp_s o_blk_out,
    input wire logic i_blk_out_ready,
    // Host memory writes.
    output mdbi_pkg::mdbi_hwr_s o_host_wr,
    input wire logic i_host_wr_ready,
    // Host memory reads.
    output mdbi_pkg::mdbi_hrd_s o_host_rd,
    input wire logic i_host_rd_ready,
    input wire mdbi_pkg::mdbi_cpl_s i_host_cpl,
    output logic o_host_cpl_ready
);
    import mdbi_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************

    // All state of the block in one record.
    typedef struct packed {
        logic [`MDBI_NCH-1:0] active;
        logic [`MDBI_NCH-1:0] done;
        logic [`MDBI_NCH-1:0][`MDBI_AW-1:0] haddr;
        logic [`MDBI_NCH-1:0][`MDBI_LW-1:0] left;
        logic [`MDBI_NCH-1:0] half_v;
        logic [`MDBI_NCH-1:0] half_hi;
        logic [`MDBI_NCH-1:0][`MDBI_SW-1:0] half_d;
        logic [`MDBI_NCH-1:0] in_rdy;
        mdbi_wr_e wr_state;
        logic [`MDBI_CW-1:0] wr_chan;
        logic [`MDBI_KW-1:0] wr_left;
        logic [`MDBI_CW-1:0] rr;
        mdbi_hwr_s hwr;
        mdbi_hrd_s hrd;
        logic [`MDBI_LW-1:0] rq_left;
        logic [`MDBI_KW-1:0] outst;
        logic cpl_rdy;
        logic [`MDBI_BW-1:0] uw;
        logic uw_v;
        logic u_hi;
        mdbi_smp_s bout;
    } mdbi_state_s;

    mdbi_state_s st_q; // Registered state.
    mdbi_state_s st_d; // Next state.

    // FIFO side signals, one set per channel.
    logic [`MDBI_NCH-1:0] f_push; // Word offered to a FIFO.
    logic [`MDBI_NCH-1:0] f_in_rdy; // FIFO has room.
    mdbi_word_s [`MDBI_NCH-1:0] f_in; // Word offered.
    logic [`MDBI_NCH-1:0] f_pop; // Word taken from a FIFO.
    logic [`MDBI_NCH-1:0] f_out_v; // FIFO holds a word.
    mdbi_word_s [`MDBI_NCH-1:0] f_out; // Head word.
    logic [`MDBI_NCH-1:0][`MDBI_KW-1:0] f_cnt; // Fill level.

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Smaller of a word count and the burst size.
    function automatic logic [`MDBI_KW-1:0] burst_of(input logic [`MDBI_LW-1:0] n);
        burst_of = (n > `MDBI_LW'(`MDBI_BURST)) ? `MDBI_BURST : `MDBI_KW'(n);
    endfunction

    // Bus word address holding a byte address.
    function automatic logic [`MDBI_AW-1:0] word_addr(input logic [`MDBI_AW-1:0] a);
        word_addr = a & `MDBI_WORD_MASK;
    endfunction

    // Next channel number in round-robin order.
    function automatic logic [`MDBI_CW-1:0] next_ch(input logic [`MDBI_CW-1:0] c);
        next_ch = (c == `MDBI_LAST_CH) ? '0 : c + `MDBI_ONE4;
    endfunction

    // ****************************************************************
    // Per-channel FIFOs
    // ****************************************************************

    // Each channel owns its FIFO, so a stalled channel never blocks a neighbour.
    for (genvar g = 0; g < `MDBI_NCH; g++) begin : g_ch
        mdbi_fifo #(
            .W(`MDBI_WW),
            .D(`MDBI_DEPTH)
        ) u_fifo (
            .i_core_clk(i_core_clk),
            .i_rst(i_rst),
            .i_in_valid(f_push[g]),
            .o_in_ready(f_in_rdy[g]),
            .i_in_data(f_in[g]),
            .o_out_valid(f_out_v[g]),
            .i_out_ready(f_pop[g]),
            .o_out_data(f_out[g]),
            .o_count(f_cnt[g])
        );
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // One process computes every channel; the host write port is the only shared piece.
    always_comb begin
        logic took; // Block sample accepted on this channel.
        logic wr_free; // Write beat register can load.
        logic found; // Arbiter found an eligible channel.
        logic [`MDBI_CW-1:0] cand; // Channel under test by the arbiter.
        logic out_free; // Generation sample register can load.
        took = 1'b0;
        wr_free = 1'b0;
        found = 1'b0;
        cand = '0;
        out_free = 1'b0;
        st_d = st_q;
        f_push = '0;
        f_in = '0;
        f_pop = '0;
        st_d.done = '0;

        // Set-up is taken only by an idle channel; after that no software is involved.
        for (int c = 0; c < `MDBI_NCH; c++) begin
            if (i_desc[c].valid && !st_q.active[c] && i_desc[c].nsamp != `MDBI_ZERO16) begin
                st_d.active[c] = 1'b1;
                st_d.haddr[c] = word_addr(i_desc[c].addr);
                st_d.left[c] = i_desc[c].nsamp;
                st_d.half_v[c] = 1'b0;
                st_d.half_hi[c] = i_desc[c].addr[`MDBI_HALF_BIT];
            end
        end

        // Packers: two samples make one bus word; odd start and end go out half-filled.
        for (int c = 0; c < `MDBI_NCH; c++) begin
            if (c != `MDBI_GEN_CH) begin
                took = st_q.in_rdy[c] && i_blk_in[c].valid;
                if (took) begin
                    st_d.left[c] = st_q.left[c] - `MDBI_ONE16;
                    if (st_q.half_hi[c]) begin
                        f_push[c] = 1'b1;
                        f_in[c].data = {i_blk_in[c].data,
                            st_q.half_v[c] ? st_q.half_d[c] : `MDBI_ZERO16};
                        f_in[c].be = st_q.half_v[c] ? `MDBI_BE_FULL : `MDBI_BE_HI;
                        st_d.half_hi[c] = 1'b0;
                        st_d.half_v[c] = 1'b0;
                    end else if (st_q.left[c] == `MDBI_ONE16) begin
                        f_push[c] = 1'b1;
                        f_in[c].data = {`MDBI_ZERO16, i_blk_in[c].data};
                        f_in[c].be = `MDBI_BE_LO;
                    end else begin
                        st_d.half_d[c] = i_blk_in[c].data;
                        st_d.half_v[c] = 1'b1;
                        st_d.half_hi[c] = 1'b1;
                    end
                end
                // Ready is registered, so it looks at the count after this cycle's push.
                st_d.in_rdy[c] = st_d.active[c] && (st_d.left[c] != `MDBI_ZERO16)
                    && (f_cnt[c] + `MDBI_KW'(f_push[c]) <= `MDBI_ROOM);
            end else begin
                st_d.in_rdy[c] = 1'b0;
            end
        end

        // Write engine: one beat register towards host, loaded whenever it is free during a burst.
        wr_free = !st_q.hwr.valid || i_host_wr_ready;
        if (st_q.hwr.valid && i_host_wr_ready) begin
            st_d.hwr.valid = 1'b0;
        end
        case (st_q.wr_state)
            MDBI_WR_IDLE: begin
                // Full bursts are preferred; a tail is sent once the block side is finished.
                cand = st_q.rr;
                for (int k = 0; k < `MDBI_NCH; k++) begin
                    if (!found && cand != `MDBI_CW'(`MDBI_GEN_CH) && f_cnt[cand] != '0 &&
                        (f_cnt[cand] >= `MDBI_BURST || st_q.left[cand] == `MDBI_ZERO16)) begin
                        found = 1'b1;
                        st_d.wr_chan = cand;
                        st_d.wr_left = burst_of(`MDBI_LW'(f_cnt[cand]));
                        st_d.wr_state = MDBI_WR_BURST;
                    end
                    cand = next_ch(cand);
                end
            end
            MDBI_WR_BURST: begin
                if (wr_free && st_q.wr_left != '0) begin
                    f_pop[st_q.wr_chan] = 1'b1;
                    st_d.hwr.valid = 1'b1;
                    st_d.hwr.chan = st_q.wr_chan;
                    st_d.hwr.addr = st_q.haddr[st_q.wr_chan];
                    st_d.hwr.word = f_out[st_q.wr_chan];
                    st_d.hwr.last = (st_q.wr_left == `MDBI_ONE3);
                    st_d.haddr[st_q.wr_chan] = st_q.haddr[st_q.wr_chan] + `MDBI_ADDR_STEP;
                    st_d.wr_left = st_q.wr_left - `MDBI_ONE3;
                end else if (st_q.wr_left == '0) begin
                    // Round robin keeps one busy channel from starving the others.
                    st_d.wr_state = MDBI_WR_IDLE;
                    st_d.rr = next_ch(st_q.wr_chan);
                end
            end
            default: begin
                st_d.wr_state = MDBI_WR_IDLE;
            end
        endcase

        // Generation channel: read requests only for words that fit in its FIFO.
        if (i_desc[`MDBI_GEN_CH].valid && !st_q.active[`MDBI_GEN_CH] &&
            i_desc[`MDBI_GEN_CH].nsamp != `MDBI_ZERO16) begin
            st_d.rq_left = `MDBI_LW'((i_desc[`MDBI_GEN_CH].nsamp
                + `MDBI_LW'(i_desc[`MDBI_GEN_CH].addr[`MDBI_HALF_BIT]) + `MDBI_ONE16) >> 1);
            st_d.u_hi = i_desc[`MDBI_GEN_CH].addr[`MDBI_HALF_BIT];
            st_d.uw_v = 1'b0;
        end
        if (st_q.hrd.valid && i_host_rd_ready) begin
            st_d.hrd.valid = 1'b0;
        end
        if (i_host_cpl.valid && st_q.cpl_rdy) begin
            f_push[`MDBI_GEN_CH] = 1'b1;
            f_in[`MDBI_GEN_CH].data = i_host_cpl.data;
            f_in[`MDBI_GEN_CH].be = `MDBI_BE_FULL;
            st_d.outst = st_q.outst - `MDBI_ONE3;
        end
        if (!st_q.hrd.valid && st_q.active[`MDBI_GEN_CH] && st_q.rq_left != `MDBI_ZERO16 &&
            (`MDBI_KW'(`MDBI_DEPTH) - f_cnt[`MDBI_GEN_CH] - st_q.outst) >=
            burst_of(st_q.rq_left)) begin
            st_d.hrd.valid = 1'b1;
            st_d.hrd.addr = st_q.haddr[`MDBI_GEN_CH];
            st_d.hrd.beats = burst_of(st_q.rq_left);
            st_d.haddr[`MDBI_GEN_CH] = st_q.haddr[`MDBI_GEN_CH]
                + (`MDBI_AW'(st_d.hrd.beats) << 2);
            st_d.rq_left = st_q.rq_left - `MDBI_LW'(st_d.hrd.beats);
            st_d.outst = st_d.outst + st_d.hrd.beats;
        end
        st_d.cpl_rdy = f_in_rdy[`MDBI_GEN_CH];

        // Unpacker: a bus word yields its low then high sample, skipping unused halves.
        if (!st_q.uw_v && f_out_v[`MDBI_GEN_CH] && st_q.active[`MDBI_GEN_CH]) begin
            f_pop[`MDBI_GEN_CH] = 1'b1;
            st_d.uw = f_out[`MDBI_GEN_CH].data;
            st_d.uw_v = 1'b1;
        end
        out_free = !st_q.bout.valid || i_blk_out_ready;
        if (st_q.bout.valid && i_blk_out_ready) begin
            st_d.bout.valid = 1'b0;
        end
        if (out_free && st_q.uw_v && st_q.left[`MDBI_GEN_CH] != `MDBI_ZERO16) begin
            st_d.bout.valid = 1'b1;
            st_d.bout.data = st_q.u_hi ? st_q.uw[`MDBI_BW-1:`MDBI_SW] : st_q.uw[`MDBI_SW-1:0];
            st_d.left[`MDBI_GEN_CH] = st_q.left[`MDBI_GEN_CH] - `MDBI_ONE16;
            st_d.u_hi = !st_q.u_hi;
            if (st_q.u_hi || st_q.left[`MDBI_GEN_CH] == `MDBI_ONE16) begin
                st_d.uw_v = 1'b0;
            end
        end

        // Completion: block side finished and nothing left in the FIFO or on the bus.
        for (int c = 0; c < `MDBI_NCH; c++) begin
            if (st_q.active[c] && st_q.left[c] == `MDBI_ZERO16 && f_cnt[c] == '0 &&
                !(st_q.wr_state == MDBI_WR_BURST && st_q.wr_chan == `MDBI_CW'(c)) &&
                !(c == `MDBI_GEN_CH && (st_q.bout.valid || st_q.outst != '0)) &&
                !(st_q.hwr.valid && st_q.hwr.chan == `MDBI_CW'(c))) begin
                st_d.active[c] = 1'b0;
                st_d.done[c] = 1'b1;
                st_d.in_rdy[c] = 1'b0;
            end
        end
    end

    // ****************************************************************
    // State register and outputs
    // ****************************************************************

    // Single state register; every output below is a field of it.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_busy = st_q.active;
    assign o_done = st_q.done;
    assign o_blk_in_ready = st_q.in_rdy;
    assign o_blk_out = st_q.bout;
    assign o_host_wr = st_q.hwr;
    assign o_host_rd = st_q.hrd;
    assign o_host_cpl_ready = st_q.cpl_rdy;

endmodule

// ---- mdbi_top_sva.sv ----
// Purpose: Port-level checker for the DMA bus interface.
// Assumes: Bound to every instance of the top module.
// Notes:   One clock, so default clocking and disable are used.
`timescale 1ns/1ps
`include "mdbi_defs.svh"

module mdbi_top_chk (
    input wire logic i_core_clk, i_rst, i_blk_out_ready, i_host_wr_ready, i_host_rd_ready,
    input wire logic [`MDBI_NCH-1:0] o_busy, o_done, o_blk_in_ready,
    input wire mdbi_pkg::mdbi_smp_s o_blk_out,
    input wire mdbi_pkg::mdbi_hwr_s o_host_wr,
    input wire mdbi_pkg::mdbi_hrd_s o_host_rd
);
    import mdbi_pkg::*;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_wr_wait; o_host_wr.valid && !i_host_wr_ready; endsequence
    sequence s_wr_mid; o_host_wr.valid && i_host_wr_ready && !o_host_wr.last; endsequence
    a_wr_hold: assert property (s_wr_wait |=> o_host_wr.valid && $stable(o_host_wr))
        else $error("write beat changed while stalled");
    a_burst_next: assert property (s_wr_mid |=> o_host_wr.valid &&
        o_host_wr.addr == $past(o_host_wr.addr) + 32'h4 &&
        o_host_wr.chan == $past(o_host_wr.chan)) else $error("burst beat broke sequence");
    a_rd_hold: assert property (o_host_rd.valid && !i_host_rd_ready |=> $stable(o_host_rd))
        else $error("read request changed while stalled");
    a_rd_size: assert property (o_host_rd.valid |-> o_host_rd.beats inside {[1:4]})
        else $error("read burst size out of range");
    a_gen_hold: assert property (o_blk_out.valid && !i_blk_out_ready |=> $stable(o_blk_out))
        else $error("gen sample changed while stalled");
    a_wr_align: assert property (o_host_wr.valid |-> o_host_wr.addr[1:0] == 2'h0 &&
        o_host_wr.word.be != 4'h0) else $error("write beat misaligned or empty");
    a_wr_chan: assert property (o_host_wr.valid |-> o_host_wr.chan != 4'h8 &&
        o_host_wr.chan <= 4'h9) else $error("write from wrong channel");
    a_gen_noin: assert property (!o_blk_in_ready[8])
        else $error("gen channel accepts samples");
    a_ready_busy: assert property ((o_blk_in_ready & ~o_busy) == '0)
        else $error("idle channel accepts samples");
    a_done_once: assert property (o_done != '0 |=> (o_done & $past(o_done)) == '0)
        else $error("done longer than one cycle");
    a_done_end: assert property ((o_done & (~$past(o_busy) | o_busy)) == '0)
        else $error("done without busy falling");
endmodule

bind mdbi_top mdbi_top_chk mdbi_top_chk_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .o_busy(o_busy), .o_done(o_done), .o_blk_in_ready(o_blk_in_ready),
    .o_blk_out(o_blk_out), .i_blk_out_ready(i_blk_out_ready), .o_host_wr(o_host_wr),
    .i_host_wr_ready(i_host_wr_ready), .o_host_rd(o_host_rd),
    .i_host_rd_ready(i_host_rd_ready));

// ---- testbench.sv ----
// Purpose: Self-checking bench for the DMA bus interface.
// Assumes: Inputs change at the falling edge; the host model answers.
// Notes:   Samples carry their own byte address so data is self-describing.
`timescale 1ns/1ps
`include "mdbi_defs.svh"

module testbench;
    import mdbi_pkg::*;
    typedef struct {int c; logic [31:0] a; logic [15:0] n; int w;} mdbi_row_s;
    logic i_core_clk = 1'b0, i_rst = 1'b1, stall = 1'b0, i_blk_out_ready = 1'b0;
    mdbi_desc_s [`MDBI_NCH-1:0] i_desc = '0;
    mdbi_smp_s [`MDBI_NCH-1:0] i_blk_in = '0;
    logic [`MDBI_NCH-1:0] o_busy, o_done, o_blk_in_ready;
    logic wr_rdy, rd_rdy, cpl_rdy;
    mdbi_smp_s o_blk_out;
    mdbi_hwr_s o_host_wr;
    mdbi_hrd_s o_host_rd;
    mdbi_cpl_s cpl;
    mdbi_hwr_s q[`MDBI_NCH][$]; // Accepted write beats, per channel.
    int n_errors = 0, num_checks = 0;
    // Rows: channel, address, samples, expected bus words.
    mdbi_row_s rows[6] = '{'{0, 32'h1000, 8, 4}, '{9, 32'h2002, 5, 3}, '{3, 32'h3000, 3, 2},
        '{7, 32'h4002, 1, 1}, '{8, 32'h5002, 5, 3}, '{8, 32'h6000, 4, 2}};
    always #5 i_core_clk = ~i_core_clk;

    mdbi_top mdbi_top_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_desc(i_desc),
        .o_busy(o_busy), .o_done(o_done), .i_blk_in(i_blk_in),
        .o_blk_in_ready(o_blk_in_ready), .o_blk_out(o_blk_out),
        .i_blk_out_ready(i_blk_out_ready), .o_host_wr(o_host_wr), .i_host_wr_ready(wr_rdy),
        .o_host_rd(o_host_rd), .i_host_rd_ready(rd_rdy), .i_host_cpl(cpl),
        .o_host_cpl_ready(cpl_rdy));
    mdbi_host_model mdbi_host_model_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_stall(stall), .i_host_rd(o_host_rd), .i_cpl_ready(cpl_rdy), .o_rd_ready(rd_rdy),
        .o_wr_ready(wr_rdy), .o_cpl(cpl));

    // Old register values are read here, before the edge's updates land.
    always @(posedge i_core_clk) begin
        if (o_host_wr.valid && wr_rdy) q[o_host_wr.chan].push_back(o_host_wr);
    end

    task automatic check(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("errors=%0d checks=%0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic give_desc(input int c, logic [31:0] a, logic [15:0] n);
        @(negedge i_core_clk);
        i_desc[c] = '{1'b1, a, n};
        @(negedge i_core_clk);
        i_desc[c].valid = 1'b0;
    endtask

    // Feeds n samples into channel c, then checks every word sent to host.
    task automatic run_acq(input int c, logic [31:0] a, logic [15:0] n, int nw,
                           bit hold);
        int k = 0, t = 0;
        bit sd = 0;
        logic [31:0] b;
        logic [3:0] be;
        mdbi_hwr_s w;
        if (hold) stall = 1'b1;
        give_desc(c, a, n);
        while (!sd && t < 400) begin
            i_blk_in[c] = '{k < n, a[15:0] + 16'(2 * k)};
            if (o_done[c]) sd = 1;
            if (i_blk_in[c].valid && o_blk_in_ready[c]) k++;
            if (hold && t == 40) begin
                check(o_blk_in_ready[c], 0);
                check(k < n, 1);
                stall = 1'b0;
            end
            @(negedge i_core_clk);
            t++;
        end
        i_blk_in[c].valid = 1'b0;
        check(sd, 1);
        check(q[c].size(), nw);
        for (int j = 0; j < nw && q[c].size() > 0; j++) begin
            w = q[c].pop_front();
            b = (a & 32'hFFFF_FFFC) + 32'(4 * j);
            be = (j == 0 && a[1]) ? 4'hC : 4'hF;
            be = be & ((j == nw - 1 && ((a[1] + n) % 2)) ? 4'h3 : 4'hF);
            check(w.addr, b);
            check(w.word.be, be);
            if (be[0]) check(w.word.data[15:0], b[15:0]);
            if (be[3]) check(w.word.data[31:16], b[15:0] + 16'h0002);
        end
    endtask

    // Pulls n generation samples out of channel 8 with a stalling consumer.
    task automatic run_gen(input logic [31:0] a, logic [15:0] n);
        int k = 0, t = 0;
        bit sd = 0;
        give_desc(8, a, n);
        while ((k < n || !sd) && t < 400) begin
            i_blk_out_ready = (t % 4) != 3;
            if (o_done[8]) sd = 1;
            if (o_blk_out.valid && i_blk_out_ready) begin
                check(o_blk_out.data, a[15:0] + 16'(2 * k));
                k++;
            end
            @(negedge i_core_clk);
            t++;
        end
        i_blk_out_ready = 1'b0;
        check(k, n);
        check(sd, 1);
    endtask

    initial begin
        repeat (12) @(negedge i_core_clk);
        check(o_busy, 0);
        check(o_host_wr.valid, 0);
        i_rst = 1'b0;
        foreach (rows[i]) begin
            if (rows[i].c == 8) run_gen(rows[i].a, rows[i].n);
            else run_acq(rows[i].c, rows[i].a, rows[i].n, rows[i].w, 0);
        end
        // Channels run side by side, one generating.
        fork
            run_acq(1, 32'h8002, 9, 5, 0);
            run_acq(2, 32'h9000, 12, 6, 0);
            run_gen(32'hA000, 7);
        join
        run_acq(4, 32'hB000, 16, 8, 1);
        give_desc(5, 32'hC000, 0);
        check(o_busy[5], 0);
        conclude();
    end

    initial begin
        #100000;
        n_errors++;
        conclude();
    end
endmodule
